// ### hdl/ckp_cfg.svh
// constants for the clock prescaler and speed select block
`ifndef CKP_CFG_SVH
`define CKP_CFG_SVH

// register indices; the byte address is four times the index
`define CKP_IDX_CORE        8'h8F
`define CKP_IDX_RELOAD      8'h97
`define CKP_IDX_SPI         8'hAF
`define CKP_IDX_STATUS      8'hF0

// reset values
`define CKP_RELOAD_RST      8'hFF
`define CKP_CORE_RST        8'h00
`define CKP_SPI_RST         8'h00

// writable bits of each register
`define CKP_CORE_MASK       8'h7F
`define CKP_SPI_MASK        8'h01

// field positions
`define CKP_BIT_SPI         0
`define CKP_BIT_STAT_X2     0
`define CKP_BIT_STAT_STRAP  1
`define CKP_BIT_STAT_BYPASS 2

// prescaler: a reload of all ones bypasses, otherwise count up to the wrap value
`define CKP_RELOAD_BYPASS   8'hFF
`define CKP_WRAP_AT         8'hFE

// six prescaled ticks per machine cycle
`define CKP_MC_LAST         3'h5

// edges after reset release before the strap is taken
`define CKP_STRAP_LAST      2'h3

// uart modes in which its speed bit acts
`define CKP_UART_MODE_SHIFT 2'h0
`define CKP_UART_MODE_FIXED 2'h2

`endif

// ### hdl/ckp_pkg.sv
// types shared by the clock prescaler and speed select block
package ckp_pkg;

  // layout of the core and peripheral speed register
  typedef struct packed {
    logic reserved;
    logic watchdog_fast_clock;
    logic counter_array_fast_clock;
    logic uart_fast_clock;
    logic timer2_fast_clock;
    logic timer1_fast_clock;
    logic timer0_fast_clock;
    logic double_speed_core;
  } ckp_core_ctrl_type;

  // one cycle enable for each peripheral
  typedef struct packed {
    logic timer0;
    logic timer1;
    logic timer2;
    logic uart;
    logic counter_array;
    logic watchdog;
    logic spi;
  } ckp_periph_en_type;

endpackage

// ### hdl/ckp_sync.sv
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
module ckp_sync (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // level in and out
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_r;

  // the first stage is read by the second stage only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// ### hdl/ckp_top.sv
// clock prescaler, core speed select and peripheral speed enables with apb registers
//
// The APB register port was decided locally.
`timescale 1ns/100ps
`include "ckp_cfg.svh"

module ckp_top
  import ckp_pkg::*;
(
  // clock and reset; pclk is the oscillator
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // non-volatile strap and uart mode
  input  wire logic              hsb_double_speed,
  input  wire logic [1:0]        uart_mode,
  // clock enables toward cpu and peripherals
  output logic                   cpu_clk_en,
  output logic                   periph_clk_en,
  output logic                   machine_cycle_en,
  output ckp_periph_en_type      periph_cycle_en,
  output logic                   double_speed_active
);

  // register state
  logic [7:0]        clock_reload_value_r;
  ckp_core_ctrl_type core_periph_speed_control_r;
  logic              spi_fast_clock_r;

  // strap capture
  logic              hsb_sync;
  logic [1:0]        strap_cnt_r;
  logic              strap_done_r;

  // clock generation state
  logic              half_phase_r;
  logic              x2_active_r;
  logic [7:0]        pre_cnt_r;
  logic [7:0]        reload_active_r;
  logic              pre_phase_r;
  logic [2:0]        mc_cnt_r;
  logic              mc_odd_r;

  // combinational terms
  logic              div2_rise;
  logic              src_tick;
  logic              bypass;
  logic              pre_wrap;
  logic              cpu_tick;
  logic              mc_end;
  logic              uart_bit_acts;
  logic              access;
  logic              wr_commit;
  logic              hit_core;
  logic              hit_reload;
  logic              hit_spi;
  logic              hit_status;
  logic [7:0]        rd_byte;

  // true when the byte address selects the register at this index
  function automatic logic addr_hit(input logic [11:0] a, input logic [7:0] idx);
    addr_hit = (a == {2'h0, idx, 2'h0});
  endfunction

  // peripheral cycle: every machine cycle, or every second one when slowed in double speed
  function automatic logic periph_go(input logic slow_bit, input logic x2, input logic end_mc,
                                     input logic odd);
    periph_go = end_mc & (~(x2 & slow_bit) | odd);
  endfunction

  ckp_sync u_hsb_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (hsb_double_speed),
    .sync_out (hsb_sync)
  );

  // ---------------- apb decode ----------------
  assign hit_core   = addr_hit(paddr, `CKP_IDX_CORE);
  assign hit_reload = addr_hit(paddr, `CKP_IDX_RELOAD);
  assign hit_spi    = addr_hit(paddr, `CKP_IDX_SPI);
  assign hit_status = addr_hit(paddr, `CKP_IDX_STATUS);
  assign access     = psel & penable;
  // writes land on the edge where the master sees pready
  assign wr_commit  = access & pready & pwrite & pstrb[0];

  always_comb begin
    rd_byte = 8'h00;
    if (hit_core) begin
      // reserved bit 7 is never stored and reads zero
      rd_byte = core_periph_speed_control_r & `CKP_CORE_MASK;
    end else if (hit_reload) begin
      rd_byte = clock_reload_value_r;
    end else if (hit_spi) begin
      rd_byte[`CKP_BIT_SPI] = spi_fast_clock_r;
    end else if (hit_status) begin
      rd_byte[`CKP_BIT_STAT_X2]     = x2_active_r;
      rd_byte[`CKP_BIT_STAT_STRAP]  = strap_done_r;
      rd_byte[`CKP_BIT_STAT_BYPASS] = bypass;
    end
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (access && !pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      pslverr <= ~(hit_core | hit_reload | hit_spi | hit_status);
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ---------------- software registers ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_reload_value_r <= `CKP_RELOAD_RST;
    end else if (wr_commit && hit_reload) begin
      clock_reload_value_r <= pwdata[7:0];
    end
  end

  // strap is taken once the synchroniser holds a settled value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_r  <= 2'h0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_cnt_r  <= strap_cnt_r + 2'h1;
      strap_done_r <= (strap_cnt_r == `CKP_STRAP_LAST);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_periph_speed_control_r <= `CKP_CORE_RST;
    end else if (!strap_done_r && strap_cnt_r == `CKP_STRAP_LAST) begin
      core_periph_speed_control_r.double_speed_core <= hsb_sync;
    end else if (wr_commit && hit_core) begin
      // bit 7 is masked off so a stray set cannot stick
      core_periph_speed_control_r <= pwdata[7:0] & `CKP_CORE_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spi_fast_clock_r <= 1'(`CKP_SPI_RST);
    end else if (wr_commit && hit_spi) begin
      spi_fast_clock_r <= pwdata[`CKP_BIT_SPI];
    end
  end

  // ---------------- divide by two and glitch-free mode switch ----------------
  // half_phase_r is the oscillator over two; it rises in the cycle where it is low
  assign div2_rise = ~half_phase_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_phase_r <= 1'b0;
    end else begin
      half_phase_r <= ~half_phase_r;
    end
  end

  // the mode only changes on a rising half-rate edge so no short tick appears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x2_active_r <= 1'b0;
    end else if (div2_rise) begin
      x2_active_r <= core_periph_speed_control_r.double_speed_core;
    end
  end

  // source clock: every oscillator edge in double speed, else half rate
  assign src_tick = x2_active_r | div2_rise;

  // ---------------- prescaler ----------------
  assign bypass   = (reload_active_r == `CKP_RELOAD_BYPASS);
  assign pre_wrap = (pre_cnt_r == `CKP_WRAP_AT);
  // 255-reload ticks per wrap, two wraps per output tick
  assign cpu_tick = src_tick & (bypass | (pre_wrap & pre_phase_r));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_r       <= `CKP_RELOAD_RST;
      reload_active_r <= `CKP_RELOAD_RST;
      pre_phase_r     <= 1'b0;
    end else if (src_tick) begin
      if (bypass) begin
        // every tick counts as a wrap, so a new reload starts cleanly
        pre_cnt_r       <= clock_reload_value_r;
        reload_active_r <= clock_reload_value_r;
        pre_phase_r     <= 1'b0;
      end else if (pre_wrap) begin
        pre_cnt_r       <= clock_reload_value_r;
        reload_active_r <= clock_reload_value_r;
        pre_phase_r     <= ~pre_phase_r;
      end else begin
        pre_cnt_r <= pre_cnt_r + 8'h01;
      end
    end
  end

  // ---------------- machine cycle ----------------
  // six prescaled ticks: 12 oscillator periods at half rate, 6 in double speed, when the reload bypasses
  assign mc_end = cpu_tick & (mc_cnt_r == `CKP_MC_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_cnt_r <= 3'h0;
    end else if (mc_end) begin
      mc_cnt_r <= 3'h0;
    end else if (cpu_tick) begin
      mc_cnt_r <= mc_cnt_r + 3'h1;
    end
  end

  // alternates each machine cycle to give the slowed peripheral rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_odd_r <= 1'b0;
    end else if (mc_end) begin
      mc_odd_r <= ~mc_odd_r;
    end
  end

  // ---------------- output enables ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en          <= 1'b0;
      periph_clk_en       <= 1'b0;
      machine_cycle_en    <= 1'b0;
      double_speed_active <= 1'b0;
    end else begin
      cpu_clk_en          <= cpu_tick;
      periph_clk_en       <= cpu_tick;
      machine_cycle_en    <= mc_end;
      double_speed_active <= x2_active_r;
    end
  end

  // the uart speed bit only matters in its shift and fixed-rate modes
  assign uart_bit_acts = (uart_mode == `CKP_UART_MODE_SHIFT) || (uart_mode == `CKP_UART_MODE_FIXED);

  // a set bit slows only when double speed is active; cleared keeps the machine cycle rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_cycle_en <= '0;
    end else begin
      periph_cycle_en.timer0        <= periph_go(core_periph_speed_control_r.timer0_fast_clock,
                                                 x2_active_r, mc_end, mc_odd_r);
      periph_cycle_en.timer1        <= periph_go(core_periph_speed_control_r.timer1_fast_clock,
                                                 x2_active_r, mc_end, mc_odd_r);
      periph_cycle_en.timer2        <= periph_go(core_periph_speed_control_r.timer2_fast_clock,
                                                 x2_active_r, mc_end, mc_odd_r);
      periph_cycle_en.uart          <= periph_go(core_periph_speed_control_r.uart_fast_clock & uart_bit_acts,
                                                 x2_active_r, mc_end, mc_odd_r);
      periph_cycle_en.counter_array <= periph_go(core_periph_speed_control_r.counter_array_fast_clock,
                                                 x2_active_r, mc_end, mc_odd_r);
      periph_cycle_en.watchdog      <= periph_go(core_periph_speed_control_r.watchdog_fast_clock,
                                                 x2_active_r, mc_end, mc_odd_r);
      periph_cycle_en.spi           <= periph_go(spi_fast_clock_r,
                                                 x2_active_r, mc_end, mc_odd_r);
    end
  end

endmodule

// ### tb/ckp_osc_model.sv
// free-running oscillator model driving the block clock input
`timescale 1ns/100ps
module ckp_osc_model #(
  parameter real HALF_NS = 20.0
) (
  // oscillator output
  output logic osc_clk
);
  // a crystal runs free, so no gating between transfers
  initial osc_clk = 1'b0;
  always #(HALF_NS) osc_clk = ~osc_clk;
endmodule

// ### tb/ckp_top_asserts.sv
// concurrent checks on the clock prescaler ports
`timescale 1ns/100ps
module ckp_top_asserts
  import ckp_pkg::*;
(
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // apb slave
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // strap and uart mode
  input wire logic              hsb_double_speed,
  input wire logic [1:0]        uart_mode,
  // enables
  input wire logic              cpu_clk_en,
  input wire logic              periph_clk_en,
  input wire logic              machine_cycle_en,
  input wire ckp_periph_en_type periph_cycle_en,
  input wire logic              double_speed_active
);
  logic [7:0]  reload_r;
  logic        t0_r;
  logic [3:0]  en_seen_r;
  logic [11:0] gap_r;
  logic [11:0] mc_gap_r;
  logic [11:0] chg_r;
  logic        seen_r;
  logic [11:0] exp_gap;
  logic        wr_hit;
  assign wr_hit = psel && penable && pready && pwrite && pstrb[0];
  assign exp_gap = (reload_r == 8'hFF) ? (double_speed_active ? 12'h001 : 12'h002) :
                   double_speed_active ? {3'h0, 8'hFF - reload_r, 1'h0} : {2'h0, 8'hFF - reload_r, 2'h0};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_r <= 8'hFF;
      t0_r <= 1'b0;
    end else if (wr_hit && paddr == 12'h25C) begin
      reload_r <= pwdata[7:0];
    end else if (wr_hit && paddr == 12'h23C) begin
      t0_r <= pwdata[1];
    end
  end
  // a new reload lands only at a wrap, so trust periods after a few enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_seen_r <= 4'h0;
    end else if (wr_hit || $changed(double_speed_active)) begin
      en_seen_r <= 4'h0;
    end else if (cpu_clk_en && en_seen_r != 4'hF) begin
      en_seen_r <= en_seen_r + 4'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r <= 12'h0;
      mc_gap_r <= 12'h0;
    end else begin
      gap_r <= cpu_clk_en ? 12'h1 : gap_r + {11'h0, gap_r != 12'hFFF};
      mc_gap_r <= machine_cycle_en ? 12'h1 : mc_gap_r + {11'h0, mc_gap_r != 12'hFFF};
    end
  end
  // wraps keep parity, which is all the mode check needs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_r <= 12'h0;
      seen_r <= 1'b0;
    end else begin
      chg_r <= $changed(double_speed_active) ? 12'h1 : chg_r + 12'h1;
      seen_r <= seen_r || $changed(double_speed_active);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence answer_seq;
    pready ##1 !pready;
  endsequence
  sequence slow_gap;
    (!periph_cycle_en.timer0)[*8];
  endsequence
  AST_APB_ANSWER: assert property (psel && penable && !pready |=> answer_seq)
    else $error("apb access not answered after one wait state");
  AST_UNMAPPED_ERR: assert property (pready |-> pslverr == !(paddr inside {12'h23C, 12'h25C, 12'h2BC, 12'h3C0}))
    else $error("error response does not match address map");
  AST_CLK_PERIOD: assert property (cpu_clk_en && en_seen_r >= 4'h3 |-> gap_r == exp_gap)
    else $error("prescaled enable period wrong");
  AST_CPU_PERIPH_SAME: assert property (cpu_clk_en == periph_clk_en)
    else $error("cpu and peripheral enables differ");
  AST_MC_PERIOD: assert property (machine_cycle_en && reload_r == 8'hFF && en_seen_r == 4'hF
                                  |-> mc_gap_r == (double_speed_active ? 12'h6 : 12'hC))
    else $error("machine cycle period wrong");
  AST_PERIPH_IGNORED: assert property (!double_speed_active && en_seen_r == 4'hF
                                       |-> periph_cycle_en == {7{machine_cycle_en}})
    else $error("peripheral speed bit acted in standard mode");
  AST_PERIPH_FAST: assert property (double_speed_active && en_seen_r == 4'hF && !t0_r
                                    |-> periph_cycle_en.timer0 == machine_cycle_en)
    else $error("cleared timer0 bit not at machine cycle rate");
  AST_PERIPH_SLOW: assert property (double_speed_active && en_seen_r == 4'hF && t0_r && periph_cycle_en.timer0
                                    |-> machine_cycle_en ##1 slow_gap)
    else $error("set timer0 bit not at half machine cycle rate");
  AST_MODE_EVEN_EDGE: assert property ($changed(double_speed_active) && seen_r |-> !chg_r[0])
    else $error("mode switch off the divided clock edge");
endmodule

bind ckp_top ckp_top_asserts i_ckp_top_asserts (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .hsb_double_speed, .uart_mode, .cpu_clk_en, .periph_clk_en, .machine_cycle_en, .periph_cycle_en,
  .double_speed_active
);

// ### tb/ckp_top_tb.sv
// self-checking bench for the clock prescaler and speed select block
`timescale 1ns/100ps
module ckp_top_tb;
  import ckp_pkg::*;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [11:0]       paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              hardware_security_byte;
  logic [1:0]        uart_mode;
  logic              cpu_en;
  logic              mc_en;
  ckp_periph_en_type pc_en;
  logic              dsa;
  logic [31:0]       rd;
  logic              err;
  int                mismatches;
  int                n_compared;
  int                g;
  int                c [4];
  logic [8:0]        rows [6];

  ckp_osc_model i_ckp_osc_model (.osc_clk(pclk));
  ckp_top i_ckp_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hsb_double_speed(hardware_security_byte), .uart_mode(uart_mode), .cpu_clk_en(cpu_en), .periph_clk_en(),
    .machine_cycle_en(mc_en), .periph_cycle_en(pc_en), .double_speed_active(dsa)
  );

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb answer", 32'h1, {31'h0, pready});
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), e, rd);
  endtask

  // period of the enable chosen by mc, after skipping a few irregular ones
  task automatic gap_of(input logic mc, input int skip);
    repeat (skip + 1) begin
      g = 0;
      do begin
        @(posedge pclk);
        g++;
      end while ((mc ? mc_en : cpu_en) !== 1'b1 && g < 4200);
    end
  endtask

  task automatic count_win;
    c = '{0, 0, 0, 0};
    repeat (24) @(posedge pclk);
    repeat (120) begin
      @(posedge pclk);
      c[0] += mc_en;
      c[1] += pc_en.timer0;
      c[2] += pc_en.uart;
      c[3] += pc_en.spi;
    end
  endtask

  function automatic int exp_gap(input logic x2, input logic [7:0] r);
    if (r == 8'hFF) return x2 ? 1 : 2;
    return (x2 ? 2 : 4) * (255 - r);
  endfunction

  task automatic final_report;
    if (mismatches == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    final_report;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    hardware_security_byte = 1'b0;
    uart_mode = 2'h0;
    rows = '{9'h0FF, 9'h000, 9'h0FE, 9'h100, 9'h180, 9'h1FF};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    rdchk(12'h23C, 32'h0);
    rdchk(12'h25C, 32'hFF);
    rdchk(12'h2BC, 32'h0);
    rdchk(12'h3C0, 32'h6);
    apb(1'b0, 12'h000, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, 12'h23C, 32'h7E);
    rdchk(12'h23C, 32'h7E);
    apb(1'b1, 12'h2BC, 32'hFF);
    rdchk(12'h2BC, 32'h01);
    apb(1'b1, 12'h25C, 32'h5A);
    rdchk(12'h25C, 32'h5A);
    foreach (rows[i]) begin
      apb(1'b1, 12'h23C, {31'h0, rows[i][8]});
      apb(1'b1, 12'h25C, {24'h0, rows[i][7:0]});
      gap_of(1'b0, 4);
      chk("enable period", exp_gap(rows[i][8], rows[i][7:0]), g);
      if (rows[i][7:0] == 8'hFF) begin
        gap_of(1'b1, 2);
        chk("machine cycle period", rows[i][8] ? 6 : 12, g);
      end
    end
    apb(1'b1, 12'h23C, 32'h7F);
    for (int m = 0; m < 4; m++) begin
      uart_mode <= m[1:0];
      count_win;
      chk("machine cycles", 20, c[0]);
      chk("timer0 pulses", 10, c[1]);
      chk("uart pulses", (m == 0 || m == 2) ? 10 : 20, c[2]);
      chk("spi pulses", 10, c[3]);
    end
    apb(1'b1, 12'h23C, 32'h7E);
    count_win;
    for (int j = 0; j < 4; j++) begin
      chk("standard pulses", 10, c[j]);
    end
    presetn <= 1'b0;
    hardware_security_byte <= 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    rdchk(12'h23C, 32'h01);
    rdchk(12'h2BC, 32'h0);
    rdchk(12'h3C0, 32'h7);
    chk("double speed after strap", 32'h1, {31'h0, dsa});
    gap_of(1'b0, 4);
    chk("strap bypass period", 1, g);
    final_report;
  end
endmodule
